// *** verilog/acdma_pkg.sv ***
/*
  acdma_pkg: constants and types for the first audio channel transfer
  controller (command port, extended registers, DMA and FIFO control).
  Assumes one 50 MHz clock and a host that follows the busy handshake.
*/
package acdma_pkg;

  // host port offsets
  localparam logic [3:0] PORT_SRST  = 4'h6;
  localparam logic [3:0] PORT_RDATA = 4'hA;
  localparam logic [3:0] PORT_CMD   = 4'hC;
  localparam logic [3:0] PORT_ICLR  = 4'hE;

  // extended register numbers
  localparam logic [7:0] REG_SAMPLE_DIV = 8'hA1;
  localparam logic [7:0] REG_FILTER_DIV = 8'hA2;
  localparam logic [7:0] REG_RELOAD_LO  = 8'hA4;
  localparam logic [7:0] REG_RELOAD_HI  = 8'hA5;
  localparam logic [7:0] REG_CHAN_MODE  = 8'hA8;
  localparam logic [7:0] REG_IRQ_CFG    = 8'hB1;
  localparam logic [7:0] REG_DRQ_CFG    = 8'hB2;
  localparam logic [7:0] REG_REC_VOL    = 8'hB4;
  localparam logic [7:0] REG_PB_SIGN    = 8'hB6;
  localparam logic [7:0] REG_FIFO_FMT   = 8'hB7;
  localparam logic [7:0] REG_XFER_CTL   = 8'hB8;
  localparam logic [7:0] REG_REQ_SIZE   = 8'hB9;
  localparam logic [7:0] REG_RST_VAL    = 8'h00;

  // commands
  localparam logic [7:0] CMD_EXT_EN  = 8'hC6;
  localparam logic [7:0] CMD_READ    = 8'hC0;
  localparam logic [7:0] CMD_MIX_ON  = 8'hD1;
  localparam logic [7:0] CMD_MIX_OFF = 8'hD3;

  // field positions
  localparam int SR_RESET   = 0;
  localparam int SR_FLUSH   = 1;
  localparam int XC_ENABLE  = 0;
  localparam int XC_AUTO    = 2;
  localparam int XC_REC     = 3;
  localparam int CM_MONITOR = 3;
  localparam int FF_WIDE    = 2;
  localparam int FF_STEREO  = 3;
  localparam int FF_SIGNED  = 5;
  localparam int PS_SIGN    = 7;
  localparam int CFG_ON     = 6;
  localparam int ST_BUSY    = 7;
  localparam int ST_RDRDY   = 6;
  localparam int ST_EMPTY   = 2;
  localparam int IC_RDRDY   = 7;

  // request sizes
  localparam logic [1:0] RS_DEMAND2 = 2'b01;
  localparam logic [1:0] RS_DEMAND4 = 2'b11;

  // cycle counts and full buffer fill level
  localparam logic [2:0] RST_BUSY_CYC = 3'd4;
  localparam logic [2:0] CMD_BUSY_CYC = 3'd1;
  localparam logic [1:0] BUF_FULL     = 2'd2;

  // command parser states
  typedef enum logic [1:0] {CMD_IDLE, CMD_WDATA, CMD_RADDR} acdma_cmd_st_t;

  // one host port access
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } acdma_host_req_t;

  // decoded sample format
  typedef struct packed {
    logic stereo;
    logic wide;
    logic signd;
  } acdma_fmt_t;

  // whole module state
  typedef struct packed {
    acdma_cmd_st_t  cmd_st;
    logic [7:0]     reg_sel;
    logic [2:0]     busy_cnt;
    logic           ext_en;
    logic           mix_on;
    logic [7:0]     rd_data;
    logic           rd_rdy;
    logic           irq_pend;
    logic [7:0]     sample_div;
    logic [7:0]     filter_div;
    logic [7:0]     reload_lo;
    logic [7:0]     reload_hi;
    logic [7:0]     chan_mode;
    logic [7:0]     irq_cfg;
    logic [7:0]     drq_cfg;
    logic [7:0]     rec_vol;
    logic [7:0]     pb_sign;
    logic [7:0]     fifo_fmt;
    logic [7:0]     xfer_ctl;
    logic [7:0]     req_size;
    logic           fmt_phase;
    logic           active;
    logic [15:0]    count;
    logic [1:0]     beat;
    logic           drq_gap;
    logic [1:0][7:0] buf_mem;
    logic           wr_ptr;
    logic           rd_ptr;
    logic [1:0]     fill;
    logic [7:0]     rdata;
    logic           drq;
    logic [7:0]     dma_rdata;
    logic           conv_valid;
    logic [7:0]     conv_data;
    logic           adc_rdy;
    logic           irq;
    logic           mute;
    logic           dac_init;
  } acdma_state_t;

  localparam acdma_state_t ACDMA_STATE_RST = '0;

endpackage

// *** verilog/acdma_top.sv ***
/*
  acdma_top: first audio channel transfer controller. Host byte ports
  (reset, command/status, read data, interrupt clear), extended
  register file, transfer counter, DMA request logic and a two-entry
  buffer between the system DMA and the converter.
  Assumes all inputs synchronous to clock_i and a DMA controller that
  acknowledges only while the request is high.
*/
`timescale 1ns/100ps
module acdma_top
  import acdma_pkg::*;
(
  // clock, reset, enable
  input  wire logic            clock_i,
  input  wire logic            srst_i,
  input  wire logic            ce_i,
  // host byte ports
  input  wire acdma_host_req_t host_req_i,
  output logic [7:0]           host_rdata_o,
  output logic                 irq_o,
  // system dma
  output logic                 drq_o,
  input  wire logic            dack_i,
  input  wire logic [7:0]      dma_wdata_i,
  output logic [7:0]           dma_rdata_o,
  // playback converter stream
  output logic                 conv_valid_o,
  output logic [7:0]           conv_data_o,
  input  wire logic            conv_ready_i,
  // record converter stream
  input  wire logic            adc_valid_i,
  input  wire logic [7:0]      adc_data_i,
  output logic                 adc_ready_o,
  // analog control
  output logic                 mixer_in_o,
  output logic                 line_mute_o,
  output logic                 dac_init_o,
  output logic                 sign_o,
  output acdma_fmt_t           fmt_o,
  output logic [1:0]           chan_o,
  output logic [7:0]           sample_div_o,
  output logic [7:0]           filter_div_o,
  output logic [7:0]           rec_vol_o
);

  acdma_state_t s_reg;  // registered state
  acdma_state_t s_next; // next state

  // extended register read-back by number
  function automatic logic [7:0] reg_rd(input acdma_state_t q,
                                        input logic [7:0] a);
    logic [7:0] v;
    v = REG_RST_VAL;
    if (a == REG_SAMPLE_DIV) begin
      v = q.sample_div;
    end else if (a == REG_FILTER_DIV) begin
      v = q.filter_div;
    end else if (a == REG_RELOAD_LO) begin
      v = q.reload_lo;
    end else if (a == REG_RELOAD_HI) begin
      v = q.reload_hi;
    end else if (a == REG_CHAN_MODE) begin
      v = q.chan_mode;
    end else if (a == REG_IRQ_CFG) begin
      v = q.irq_cfg;
    end else if (a == REG_DRQ_CFG) begin
      v = q.drq_cfg;
    end else if (a == REG_REC_VOL) begin
      v = q.rec_vol;
    end else if (a == REG_PB_SIGN) begin
      v = q.pb_sign;
    end else if (a == REG_FIFO_FMT) begin
      v = q.fifo_fmt;
    end else if (a == REG_XFER_CTL) begin
      v = q.xfer_ctl;
    end else if (a == REG_REQ_SIZE) begin
      v = q.req_size;
    end
    return v;
  endfunction

  // next-state logic; order matters: read clears come before sets, soft reset clears last
  always_comb begin : next_state
    logic       cmd_wr;  // accepted command/data byte
    logic       rec;     // record direction
    logic       dma_go;  // honoured dma acknowledge
    logic       push;    // buffer write
    logic       pop;     // buffer read
    logic [1:0] lim;     // last beat of a burst
    logic [7:0] d;       // written byte
    logic [15:0] inc;    // counter plus one
    cmd_wr = 1'b0;
    rec = 1'b0;
    dma_go = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    lim = 2'd0;
    d = host_req_i.wdata;
    inc = '0;
    s_next = s_reg;
    s_next.dac_init = 1'b0;
    s_next.rdata = REG_RST_VAL;

    // busy countdown after each accepted byte
    if (s_reg.busy_cnt != 3'd0) begin
      s_next.busy_cnt = s_reg.busy_cnt - 3'd1;
    end

    // host reads; side effects clear flags
    if (host_req_i.rd) begin
      if (host_req_i.addr == PORT_CMD) begin
        s_next.rdata[ST_BUSY] = (s_reg.busy_cnt != 3'd0);
        s_next.rdata[ST_RDRDY] = s_reg.rd_rdy;
        s_next.rdata[ST_EMPTY] = (s_reg.fill == 2'd0);
      end else if (host_req_i.addr == PORT_ICLR) begin
        s_next.rdata[IC_RDRDY] = s_reg.rd_rdy;
        s_next.irq_pend = 1'b0;
      end else if (host_req_i.addr == PORT_RDATA) begin
        s_next.rdata = s_reg.rd_data;
        s_next.rd_rdy = 1'b0;
      end
    end

    // bytes written while busy are dropped
    cmd_wr = host_req_i.wr && (host_req_i.addr == PORT_CMD)
             && (s_reg.busy_cnt == 3'd0);
    if (cmd_wr) begin
      s_next.busy_cnt = CMD_BUSY_CYC;
      case (s_reg.cmd_st)
        CMD_IDLE: begin
          if (d == CMD_EXT_EN) begin
            s_next.ext_en = 1'b1;
          end else if (d == CMD_MIX_ON) begin
            s_next.mix_on = 1'b1;
          end else if (d == CMD_MIX_OFF) begin
            s_next.mix_on = 1'b0;
          end else if (s_reg.ext_en && d == CMD_READ) begin
            s_next.cmd_st = CMD_RADDR;
          end else if (s_reg.ext_en
                       && (d[7:4] == 4'hA || d[7:4] == 4'hB)) begin
            s_next.reg_sel = d;
            s_next.cmd_st = CMD_WDATA;
          end
        end
        CMD_WDATA: begin
          s_next.cmd_st = CMD_IDLE;
          if (s_reg.reg_sel == REG_SAMPLE_DIV) begin
            s_next.sample_div = d;
          end else if (s_reg.reg_sel == REG_FILTER_DIV) begin
            s_next.filter_div = d;
          end else if (s_reg.reg_sel == REG_RELOAD_LO) begin
            s_next.reload_lo = d;
          end else if (s_reg.reg_sel == REG_RELOAD_HI) begin
            s_next.reload_hi = d;
          end else if (s_reg.reg_sel == REG_CHAN_MODE) begin
            s_next.chan_mode = d;
          end else if (s_reg.reg_sel == REG_IRQ_CFG) begin
            s_next.irq_cfg = d;
          end else if (s_reg.reg_sel == REG_DRQ_CFG) begin
            s_next.drq_cfg = d;
          end else if (s_reg.reg_sel == REG_REC_VOL) begin
            s_next.rec_vol = d;
          end else if (s_reg.reg_sel == REG_PB_SIGN) begin
            s_next.pb_sign = d;
            s_next.dac_init = 1'b1;
          end else if (s_reg.reg_sel == REG_FIFO_FMT) begin
            s_next.fifo_fmt = d;
            s_next.fmt_phase = !s_reg.fmt_phase;
            if (!s_reg.fmt_phase) begin
              s_next.dac_init = 1'b1;
            end
          end else if (s_reg.reg_sel == REG_XFER_CTL) begin
            s_next.xfer_ctl = d;
            if (d[XC_ENABLE] && !s_reg.xfer_ctl[XC_ENABLE]) begin
              s_next.active = 1'b1;
              s_next.count = {s_reg.reload_hi, s_reg.reload_lo};
              s_next.beat = 2'd0;
            end else if (!d[XC_ENABLE]) begin
              s_next.active = 1'b0;
            end
          end else if (s_reg.reg_sel == REG_REQ_SIZE) begin
            s_next.req_size = d;
          end
        end
        CMD_RADDR: begin
          s_next.rd_data = reg_rd(s_reg, d);
          s_next.rd_rdy = 1'b1;
          s_next.cmd_st = CMD_IDLE;
        end
        default: begin
          s_next.cmd_st = CMD_IDLE;
        end
      endcase
    end

    // direction decides who fills the buffer
    rec = s_reg.xfer_ctl[XC_REC];
    dma_go = dack_i && s_reg.drq && s_reg.active;
    if (rec) begin
      push = adc_valid_i && s_reg.adc_rdy;
      pop = dma_go;
    end else begin
      push = dma_go;
      pop = s_reg.conv_valid && conv_ready_i;
    end

    // two-entry buffer
    if (push) begin
      s_next.buf_mem[s_reg.wr_ptr] = rec ? adc_data_i : dma_wdata_i;
      s_next.wr_ptr = !s_reg.wr_ptr;
    end
    if (pop) begin
      s_next.rd_ptr = !s_reg.rd_ptr;
    end
    if (push && !pop) begin
      s_next.fill = s_reg.fill + 2'd1;
    end else if (pop && !push) begin
      s_next.fill = s_reg.fill - 2'd1;
    end

    if (s_reg.req_size[1:0] == RS_DEMAND2) begin
      lim = 2'd1;
    end else if (s_reg.req_size[1:0] == RS_DEMAND4) begin
      lim = 2'd3;
    end
    s_next.drq_gap = 1'b0;
    if (dma_go) begin
      if (s_reg.beat == lim) begin
        s_next.beat = 2'd0;
        s_next.drq_gap = 1'b1;
      end else begin
        s_next.beat = s_reg.beat + 2'd1;
      end
      inc = s_reg.count + 16'h0001;
      s_next.count = inc;
      if (inc == 16'h0000) begin
        s_next.irq_pend = 1'b1;
        if (s_reg.xfer_ctl[XC_AUTO]) begin
          s_next.count = {s_reg.reload_hi, s_reg.reload_lo};
        end else begin
          s_next.active = 1'b0;
        end
      end
    end

    // software reset port; acts regardless of busy
    if (host_req_i.wr && host_req_i.addr == PORT_SRST) begin
      if (d[SR_RESET]) begin
        // mixer input off, extended mode off
        s_next.ext_en = 1'b0;
        s_next.mix_on = 1'b0;
        s_next.cmd_st = CMD_IDLE;
        s_next.busy_cnt = RST_BUSY_CYC;
        s_next.rd_rdy = 1'b0;
        s_next.irq_pend = 1'b0;
        s_next.active = 1'b0;
        s_next.fmt_phase = 1'b0;
        s_next.chan_mode = REG_RST_VAL;
        s_next.xfer_ctl = REG_RST_VAL;
        s_next.req_size = REG_RST_VAL;
        s_next.fifo_fmt = REG_RST_VAL;
        s_next.pb_sign = REG_RST_VAL;
        s_next.irq_cfg = REG_RST_VAL;
        s_next.drq_cfg = REG_RST_VAL;
      end
      if (d[SR_FLUSH]) begin
        s_next.fill = 2'd0;
        s_next.wr_ptr = 1'b0;
        s_next.rd_ptr = 1'b0;
      end
    end

    // registered outputs from the settled next state
    rec = s_next.xfer_ctl[XC_REC];
    s_next.drq = s_next.active && s_next.drq_cfg[CFG_ON]
                 && !s_next.drq_gap
                 && (rec ? (s_next.fill != 2'd0)
                         : (s_next.fill != BUF_FULL));
    s_next.dma_rdata = s_next.buf_mem[s_next.rd_ptr];
    s_next.conv_valid = !rec && (s_next.fill != 2'd0);
    s_next.conv_data = s_next.buf_mem[s_next.rd_ptr];
    s_next.adc_rdy = rec && (s_next.fill != BUF_FULL);
    s_next.irq = s_next.irq_pend && s_next.irq_cfg[CFG_ON];
    s_next.mute = rec && !s_next.chan_mode[CM_MONITOR];
  end

  // state register; clock enable freezes everything
  always_ff @(posedge clock_i) begin : state_reg
    if (srst_i) begin
      s_reg <= ACDMA_STATE_RST;
    end else if (ce_i) begin
      s_reg <= s_next;
    end
  end

  // outputs straight from state flops
  assign host_rdata_o = s_reg.rdata;
  assign irq_o        = s_reg.irq;
  assign drq_o        = s_reg.drq;
  assign dma_rdata_o  = s_reg.dma_rdata;
  assign conv_valid_o = s_reg.conv_valid;
  assign conv_data_o  = s_reg.conv_data;
  assign adc_ready_o  = s_reg.adc_rdy;
  assign mixer_in_o   = s_reg.mix_on;
  assign line_mute_o  = s_reg.mute;
  assign dac_init_o   = s_reg.dac_init;
  assign sign_o       = s_reg.pb_sign[PS_SIGN];
  // format fields of the last written value
  assign fmt_o        = '{stereo: s_reg.fifo_fmt[FF_STEREO],
                          wide:   s_reg.fifo_fmt[FF_WIDE],
                          signd:  s_reg.fifo_fmt[FF_SIGNED]};
  assign chan_o       = s_reg.chan_mode[1:0];
  assign sample_div_o = s_reg.sample_div;
  assign filter_div_o = s_reg.filter_div;
  assign rec_vol_o    = s_reg.rec_vol;

  // checks share one clock and reset
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (srst_i);

  chk_reset_full_flush: assert property (
    ce_i && host_req_i.wr && host_req_i.addr == PORT_SRST
    && host_req_i.wdata == 8'h03 |=> s_reg.fill == 2'd0 && !conv_valid_o)
    else $error("reset with flush left buffer data");

  chk_reset_mixer_off: assert property (
    ce_i && host_req_i.wr && host_req_i.addr == PORT_SRST
    && host_req_i.wdata[SR_RESET] |=> !mixer_in_o && !s_reg.ext_en)
    else $error("soft reset kept mixer input or extended mode");

  chk_ext_mode_gate: assert property (
    ce_i && host_req_i.wr && host_req_i.addr == PORT_CMD
    && s_reg.busy_cnt == 3'd0 && !s_reg.ext_en
    && s_reg.cmd_st == CMD_IDLE |=> s_reg.cmd_st == CMD_IDLE)
    else $error("extended command taken before enable");

  chk_line_mute_map: assert property (
    ce_i |=> line_mute_o == (s_reg.xfer_ctl[XC_REC]
                             && !s_reg.chan_mode[CM_MONITOR]))
    else $error("line mute does not follow direction and monitor");

  chk_stop_at_once: assert property (
    ce_i && host_req_i.wr && host_req_i.addr == PORT_CMD
    && s_reg.busy_cnt == 3'd0 && s_reg.cmd_st == CMD_WDATA
    && s_reg.reg_sel == REG_XFER_CTL && !host_req_i.wdata[XC_ENABLE]
    |=> !drq_o && !s_reg.active)
    else $error("request still high after enable cleared");

  chk_irq_read_clear: assert property (
    ce_i && host_req_i.rd && host_req_i.addr == PORT_ICLR
    && !(dack_i && drq_o && s_reg.count == 16'hFFFF) |=> !s_reg.irq_pend)
    else $error("interrupt port read did not clear request");

  chk_busy_after_byte: assert property (
    ce_i && host_req_i.wr && host_req_i.addr == PORT_CMD
    && s_reg.busy_cnt == 3'd0 |=> s_reg.busy_cnt != 3'd0)
    else $error("busy flag not raised for accepted byte");

  chk_read_back_ready: assert property (
    ce_i && host_req_i.wr && host_req_i.addr == PORT_CMD
    && s_reg.busy_cnt == 3'd0 && s_reg.cmd_st == CMD_RADDR
    |=> s_reg.rd_rdy && s_reg.cmd_st == CMD_IDLE)
    else $error("read-back did not set ready");

  chk_single_request: assert property (
    ce_i && drq_o && dack_i && s_reg.req_size[1:0] == 2'b00 |=> !drq_o)
    else $error("single mode request not dropped after ack");

  chk_rollover_irq: assert property (
    ce_i && drq_o && dack_i && s_reg.active
    && s_reg.count == 16'hFFFF |=> s_reg.irq_pend
    && (s_reg.active == $past(s_reg.xfer_ctl[XC_AUTO])))
    else $error("rollover did not interrupt or stop correctly");

endmodule // acdma_top

// *** verification/acdma_far_model.sv ***
/*
  acdma_far_model: system dma controller and playback/record converter
  standing beside acdma_top, with stalls drawn from a fixed seed.
  Assumes a level request and one byte for each acknowledged cycle.
*/
`timescale 1ns/100ps
module acdma_far_model (
  // clock
  input  wire logic       clock_i,
  // dma side
  input  wire logic       drq_i,
  output logic            dack_o,
  output logic [7:0]      wdata_o,
  // converter side
  input  wire logic       cv_valid_i,
  input  wire logic [7:0] cv_data_i,
  output logic            cv_ready_o,
  output logic            ad_valid_o,
  output logic [7:0]      ad_data_o,
  input  wire logic       ad_ready_i,
  input  wire logic       rec_i,
  // record byte offered to the dma
  input  wire logic [7:0] rdata_i
);
  integer     seed      = 62; // fixed seed for stalls
  int         acked     = 0;  // bytes moved by the dma
  int         burst     = 0;  // acks within one request
  int         burst_max = 0;  // largest burst seen
  int         bad       = 0;  // playback or record bytes that came out wrong
  logic [7:0] q[$];           // playback bytes still in flight
  logic [7:0] rq[$];          // record bytes handed to the design

  initial begin
    dack_o = 1'b0;
    wdata_o = 8'h00;
    cv_ready_o = 1'b0;
    ad_valid_o = 1'b0;
    ad_data_o = 8'h00;
  end

  // a gap after each ack, as a real controller needs several cycles
  always @(posedge clock_i) begin
    if (ad_valid_o && ad_ready_i)
      rq.push_back(ad_data_o);
    if (drq_i && dack_o) begin
      acked++;
      burst++;
      if (!rec_i)
        q.push_back(wdata_o);
      else if (rq.size() == 0 || rq.pop_front() !== rdata_i)
        bad++;
    end else if (!drq_i)
      burst = 0;
    if (burst > burst_max)
      burst_max = burst;
    dack_o <= drq_i && !dack_o && ($random(seed) % 4 != 0);
    // data line never shows a stale byte between acks
    wdata_o <= dack_o ? 8'($random(seed)) : ~wdata_o;
    // record bytes left over at a direction change are not playback data
    if (cv_valid_i && cv_ready_o)
      if (q.size() == 0 ? !rec_i : q.pop_front() !== cv_data_i)
        bad++;
    cv_ready_o <= 1'($random(seed));
    // record word held until taken
    if (!ad_valid_o || ad_ready_i) begin
      ad_valid_o <= rec_i && 1'($random(seed));
      ad_data_o  <= 8'($random(seed));
    end
  end
endmodule // acdma_far_model

// *** verification/tb.sv ***
/*
  tb: self-checking bench for acdma_top, host byte ports driven here,
  far side from acdma_far_model. Assumes the busy spacing of one cycle.
*/
`timescale 1ns/100ps
module tb;
  import acdma_pkg::*;
  logic            clock_i, srst_i, irq, drq, dack, cv_v, cv_r, ad_v, ad_r, rec;
  logic            mix, mute, init, sign, seen_init, ce;
  logic [7:0]      rdata, wd, rd8, cv_d, ad_d, sdiv, fdiv, rvol, d;
  logic [1:0]      chan;
  acdma_host_req_t req;
  acdma_fmt_t      fmt;
  int              err_total = 0, samples_checked = 0, base, n, k;
  integer          seed;
  logic [7:0]      vals [5];
  logic [7:0]      rl [5] = '{REG_SAMPLE_DIV, REG_FILTER_DIV, REG_RELOAD_LO,
                              REG_RELOAD_HI, REG_REC_VOL};
  logic [7:0]      fmts [8] = '{8'hD0, 8'hF0, 8'hD4, 8'hF4, 8'h98, 8'hB8, 8'h9C, 8'hBC};
  logic [1:0]      rs [3] = '{2'b00, 2'b01, 2'b11};
  int              bm [3] = '{1, 2, 4};

  acdma_top dut_u (.clock_i(clock_i), .srst_i(srst_i), .ce_i(ce), .host_req_i(req),
    .host_rdata_o(rdata), .irq_o(irq), .drq_o(drq), .dack_i(dack), .dma_wdata_i(wd),
    .dma_rdata_o(rd8), .conv_valid_o(cv_v), .conv_data_o(cv_d), .conv_ready_i(cv_r),
    .adc_valid_i(ad_v), .adc_data_i(ad_d), .adc_ready_o(ad_r), .mixer_in_o(mix),
    .line_mute_o(mute), .dac_init_o(init), .sign_o(sign), .fmt_o(fmt), .chan_o(chan),
    .sample_div_o(sdiv), .filter_div_o(fdiv), .rec_vol_o(rvol));
  acdma_far_model far_u (.clock_i(clock_i), .drq_i(drq), .dack_o(dack), .wdata_o(wd),
    .cv_valid_i(cv_v), .cv_data_i(cv_d), .cv_ready_o(cv_r), .ad_valid_o(ad_v),
    .ad_data_o(ad_d), .ad_ready_i(ad_r), .rec_i(rec), .rdata_i(rd8));

  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  // the init pulse lasts one cycle, so latch it
  always @(posedge clock_i) if (init === 1'b1) seen_init <= 1'b1;

  task automatic cyc(input int c);
    repeat (c) @(posedge clock_i);
  endtask
  task automatic chk(input string nm, input logic [15:0] s, e);
    samples_checked++;
    if (s !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  // one port write, then spacing that clears the busy time
  task automatic pw(input logic [3:0] a, input logic [7:0] b);
    req.wr    <= 1'b1;
    req.addr  <= a;
    req.wdata <= b;
    cyc(1);
    req.wr <= 1'b0;
    cyc(a == PORT_SRST ? 6 : 2);
  endtask
  task automatic pr(input logic [3:0] a, output logic [7:0] b);
    req.rd   <= 1'b1;
    req.addr <= a;
    cyc(1);
    req.rd <= 1'b0;
    #1 b = rdata;
    cyc(1);
  endtask
  task automatic wreg(input logic [7:0] r, b);
    pw(PORT_CMD, r);
    pw(PORT_CMD, b);
    cyc(1);
  endtask
  task automatic rreg(input logic [7:0] r, output logic [7:0] b);
    logic [7:0] s;
    pw(PORT_CMD, CMD_READ);
    pw(PORT_CMD, r);
    pr(PORT_CMD, s);
    chk("read_ready", s[ST_RDRDY], 1'b1);
    pr(PORT_RDATA, b);
  endtask
  task automatic wait_irq();
    k = 0;
    while (irq !== 1'b1 && k < 3000) begin
      cyc(1);
      k++;
    end
    chk("irq", irq, 1'b1);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // watchdog, far beyond the expected run
  initial begin
    cyc(40000);
    err_total++;
    end_of_test();
  end

  initial begin
    seed = 62;
    srst_i = 1'b1;
    req = '0;
    ce = 1'b1;
    rec = 1'b0;
    seen_init = 1'b0;
    cyc(3);
    srst_i <= 1'b0;
    cyc(1);
    // register access refused until the extended enable
    wreg(REG_SAMPLE_DIV, 8'h5A);
    pw(PORT_CMD, CMD_EXT_EN);
    rreg(REG_SAMPLE_DIV, d);
    chk("pre_enable", d, 8'h00);
    for (int i = 0; i < 5; i++) begin
      vals[i] = 8'($random(seed));
      wreg(rl[i], vals[i]);
      rreg(rl[i], d);
      chk("reg_rw", d, vals[i]);
    end
    chk("sdiv", sdiv, vals[0]);
    chk("fdiv", fdiv, vals[1]);
    chk("rvol", rvol, vals[4]);
    wreg(8'hB3, 8'hFF);
    rreg(8'hB3, d);
    chk("unmapped", d, 8'h00);
    // mixer gating, and the soft reset dropping it
    // settle time, scaled
    cyc(20);
    pw(PORT_CMD, CMD_MIX_ON);
    chk("mixer_on", mix, 1'b1);
    wreg(REG_XFER_CTL, 8'h0C);
    pw(PORT_CMD, CMD_MIX_OFF);
    chk("mixer_off", mix, 1'b0);
    pw(PORT_CMD, CMD_MIX_ON);
    pw(PORT_SRST, 8'h03);
    chk("reset_mixer", mix, 1'b0);
    // enable low freezes the command port
    ce <= 1'b0;
    pw(PORT_CMD, CMD_MIX_ON);
    chk("ce_hold", mix, 1'b0);
    ce <= 1'b1;
    pr(PORT_CMD, d);
    chk("status", d, 8'h04);
    pw(PORT_CMD, CMD_EXT_EN);
    rreg(REG_XFER_CTL, d);
    chk("reset_ctl", d, 8'h00);
    // direction, channels and the record monitor
    wreg(REG_CHAN_MODE, 8'h02);
    chk("mono", chan, 2'b10);
    wreg(REG_XFER_CTL, 8'h08);
    chk("rec_mute", mute, 1'b1);
    wreg(REG_CHAN_MODE, 8'h09);
    chk("stereo", chan, 2'b01);
    chk("monitor", mute, 1'b0);
    wreg(REG_CHAN_MODE, 8'h01);
    chk("no_monitor", mute, 1'b1);
    wreg(REG_XFER_CTL, 8'h00);
    chk("play_unmute", mute, 1'b0);
    for (int i = 0; i < 8; i++) begin
      seen_init = 1'b0;
      wreg(REG_FIFO_FMT, i[0] ? 8'h71 : 8'h51);
      chk("fmt_init", seen_init, 1'b1);
      wreg(REG_FIFO_FMT, fmts[i]);
      chk("fmt", fmt, {i[2], i[1], i[0]});
    end
    seen_init = 1'b0;
    wreg(REG_PB_SIGN, 8'h80);
    chk("sign_set", sign, 1'b1);
    chk("sign_init", seen_init, 1'b1);
    wreg(REG_PB_SIGN, 8'h00);
    chk("sign_clr", sign, 1'b0);
    wreg(REG_IRQ_CFG, 8'h50);
    wreg(REG_DRQ_CFG, 8'h50);
    // normal blocks, both directions, every request size
    for (int j = 0; j < 6; j++) begin
      rec <= j > 2;
      n = 4 + {$random(seed)} % 6;
      wreg(REG_RELOAD_LO, 8'(-n));
      wreg(REG_RELOAD_HI, 8'hFF);
      wreg(REG_REQ_SIZE, rs[j % 3]);
      base = far_u.acked;
      far_u.burst_max = 0;
      wreg(REG_XFER_CTL, {4'h0, rec, 3'b001});
      wait_irq();
      chk("bytes", 16'(far_u.acked - base), 16'(n));
      chk("burst", far_u.burst_max <= bm[j % 3], 1'b1);
      pr(PORT_ICLR, d);
      cyc(2);
      chk("irq_clear", irq, 1'b0);
      chk("normal_stop", drq, 1'b0);
      wreg(REG_XFER_CTL, {4'h0, rec, 3'b000});
    end
    // leftover record bytes drain before playback checking resumes
    wreg(REG_XFER_CTL, 8'h00);
    cyc(20);
    rec <= 1'b0;
    // auto blocks continue, then end on a block boundary
    wreg(REG_RELOAD_LO, 8'hF0);
    base = far_u.acked;
    wreg(REG_XFER_CTL, 8'h05);
    wait_irq();
    pr(PORT_ICLR, d);
    cyc(30);
    chk("auto_more", far_u.acked - base > 16, 1'b1);
    wreg(REG_XFER_CTL, 8'h01);
    wait_irq();
    cyc(200);
    chk("auto_end", 16'((far_u.acked - base) % 16), 16'h0000);
    chk("auto_drq", drq, 1'b0);
    chk("play_data", 16'(far_u.bad), 16'h0000);
    pr(PORT_CMD, d);
    chk("drained", d[ST_EMPTY], 1'b1);
    // clearing the enable stops a long block at once
    wreg(REG_RELOAD_HI, 8'h80);
    wreg(REG_XFER_CTL, 8'h00);
    n = far_u.acked;
    wreg(REG_XFER_CTL, 8'h01);
    cyc(20);
    chk("stop_ran", far_u.acked > n, 1'b1);
    wreg(REG_XFER_CTL, 8'h00);
    chk("stop_now", drq, 1'b0);
    base = far_u.acked;
    cyc(20);
    chk("stop_acks", 16'(far_u.acked - base), 16'h0000);
    end_of_test();
  end
endmodule // tb
